// [verilog/charger_status_flag_bank.sv]
// Operation
// - input byte bit5 shows watchdog expired
// - input byte bit4 shows weak adapter
// - input byte bit3 shows input power good
// - input bits2..0 show source2, source1, bus present
// - bits7-5 charge phase code
// - bits4-1 input source type code
// - phase byte bit0 adapter detection done
// - optimizer byte bits7-6 optimizer state
// - optimizer byte bit2 die thermal regulation
// - optimizer byte bit1 only during data-line detect
// - optimizer byte bit0 battery present
// - timer byte bits7,6 blocking pairs fitted
// - timer byte bit5 conversion done, single mode
// - timer byte bit4 system minimum regulation
// - timer bits3..1 fast, trickle, precharge expired
// - thermistor bits3..0 cold cool warm hot
// - protection byte bit7 discharge current regulating
// - protection bits6..0 seven protection conditions
// - secondary bits7,6 rail short, rail overvoltage
// - secondary bit2 thermal shutdown active
// - flag bits7..5 latch rising regulation, watchdog
// - every register resets to zero
// - unmasked flag event pulses host interrupt
`timescale 1ns/1ps
`include "charger_status_params.svh"

module charger_status_flag_bank (
   // clock and reset
   input  wire logic                        ref_clk_i,
   input  wire logic                        rstn_i,
   // analog monitor levels, asynchronous
   input  wire charger_status_pkg::monitor_t monitor_i,
   // mask bits of the first flag register, same clock
   input  wire logic [7:0]                  event_mask_i,
   // register read port from the serial engine
   input  wire logic                        rd_en_i,
   input  wire logic [7:0]                  rd_addr_i,
   output logic [7:0]                       rd_data_o,
   output logic                             rd_valid_o,
   // interrupt request
   output logic                             int_pulse_o
);

   charger_status_pkg::bank_state_t state_r;
   charger_status_pkg::bank_state_t state_nxt;

   always_comb begin
      charger_status_pkg::monitor_t m;
      charger_status_pkg::monitor_t p;
      logic [7:0] set_ev;
      logic [7:0] clr_ev;
      logic [7:0] rd_byte;
      m       = state_r.sync2;
      p       = state_r.prev;
      set_ev  = 8'h00;
      clr_ev  = 8'h00;
      rd_byte = `CSB_UNMAPPED_BYTE;
      state_nxt = state_r;

      // multi-bit codes may tear for one cycle on a change; they settle next sample
      state_nxt.sync1 = monitor_i;
      state_nxt.sync2 = state_r.sync1;
      state_nxt.prev  = state_r.sync2;

      set_ev[`CSB_FLAG_ICURR] = m.input_current_regulating & ~p.input_current_regulating;
      set_ev[`CSB_FLAG_VLIM]  = m.input_voltage_regulating & ~p.input_voltage_regulating;
      set_ev[`CSB_FLAG_WDOG]  = m.watchdog_expired_status & ~p.watchdog_expired_status;
      set_ev[`CSB_FLAG_WEAK]  = m.weak_source_status & ~p.weak_source_status;
      set_ev[`CSB_FLAG_GOOD]  = m.input_good_status ^ p.input_good_status;
      set_ev[`CSB_FLAG_SRC2]  = m.second_source_present ^ p.second_source_present;
      set_ev[`CSB_FLAG_SRC1]  = m.first_source_present ^ p.first_source_present;
      set_ev[`CSB_FLAG_BUS]   = m.bus_input_present ^ p.bus_input_present;

      if (rd_addr_i == `CSB_ADDR_INPUT) begin
         rd_byte = {m.input_current_regulating,
                    m.input_voltage_regulating,
                    m.watchdog_expired_status,
                    m.weak_source_status,
                    m.input_good_status,
                    m.second_source_present,
                    m.first_source_present,
                    m.bus_input_present};
      end else if (rd_addr_i == `CSB_ADDR_PHASE) begin
         rd_byte = {m.charge_phase,
                    m.input_source_type,
                    m.adapter_detect_done};
      end else if (rd_addr_i == `CSB_ADDR_OPTIMIZER) begin
         rd_byte = {m.current_optimizer_state,
                    3'h0,
                    m.die_thermal_regulation,
                    m.data_line_detect_busy,
                    m.battery_present};
      end else if (rd_addr_i == `CSB_ADDR_TIMERS) begin
         rd_byte = {m.second_blocking_pair_fitted,
                    m.first_blocking_pair_fitted,
                    m.conversion_done,
                    m.system_min_regulation,
                    m.fast_timer_expired,
                    m.trickle_timer_expired,
                    m.precharge_timer_expired,
                    1'b0};
      end else if (rd_addr_i == `CSB_ADDR_THERMISTOR) begin
         rd_byte = {4'h0,
                    m.thermistor_cold,
                    m.thermistor_cool,
                    m.thermistor_warm,
                    m.thermistor_hot};
      end else if (rd_addr_i == `CSB_ADDR_PROT_PRI) begin
         rd_byte = {m.discharge_current_regulating,
                    m.bus_overvoltage,
                    m.battery_overvoltage,
                    m.bus_overcurrent,
                    m.battery_overcurrent,
                    m.converter_overcurrent,
                    m.second_source_overvoltage,
                    m.first_source_overvoltage};
      end else if (rd_addr_i == `CSB_ADDR_PROT_SEC) begin
         rd_byte = {m.system_rail_short,
                    m.system_rail_overvoltage,
                    3'h0,
                    m.thermal_shutdown_active,
                    2'h0};
      end else if (rd_addr_i == `CSB_ADDR_FLAGS0) begin
         rd_byte = state_r.flags;
         // only the bits actually returned are cleared
         clr_ev  = rd_en_i ? state_r.flags : 8'h00;
      end

      // a new event in the clearing cycle survives the read
      state_nxt.flags     = (state_r.flags & ~clr_ev) | set_ev;
      state_nxt.rd_valid  = rd_en_i;
      state_nxt.rd_data   = rd_en_i ? rd_byte : state_r.rd_data;
      state_nxt.int_pulse = |(set_ev & ~event_mask_i);
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign rd_data_o   = state_r.rd_data;
   assign rd_valid_o  = state_r.rd_valid;
   assign int_pulse_o = state_r.int_pulse;

endmodule

// [verilog/charger_status_params.svh]
`ifndef CHARGER_STATUS_PARAMS_SVH
`define CHARGER_STATUS_PARAMS_SVH

// register offsets
`define CSB_ADDR_INPUT      8'h1b
`define CSB_ADDR_PHASE      8'h1c
`define CSB_ADDR_OPTIMIZER  8'h1d
`define CSB_ADDR_TIMERS     8'h1e
`define CSB_ADDR_THERMISTOR 8'h1f
`define CSB_ADDR_PROT_PRI   8'h20
`define CSB_ADDR_PROT_SEC   8'h21
`define CSB_ADDR_FLAGS0     8'h22

// reset and unmapped values
`define CSB_RESET_BYTE      8'h00
`define CSB_UNMAPPED_BYTE   8'h00

// event flag bit positions
`define CSB_FLAG_ICURR      7
`define CSB_FLAG_VLIM       6
`define CSB_FLAG_WDOG       5
`define CSB_FLAG_WEAK       4
`define CSB_FLAG_GOOD       3
`define CSB_FLAG_SRC2       2
`define CSB_FLAG_SRC1       1
`define CSB_FLAG_BUS        0

`endif

// [verilog/charger_status_pkg.sv]
package charger_status_pkg;

   typedef enum logic [2:0] {
      PHASE_IDLE    = 3'h0,
      PHASE_TRICKLE = 3'h1,
      PHASE_PRE     = 3'h2,
      PHASE_CC      = 3'h3,
      PHASE_CV      = 3'h4,
      PHASE_RSVD    = 3'h5,
      PHASE_TOPOFF  = 3'h6,
      PHASE_DONE    = 3'h7
   } charge_phase_t;

   typedef enum logic [3:0] {
      SRC_NONE          = 4'h0,
      SRC_STD_DOWN      = 4'h1,
      SRC_CHG_DOWN      = 4'h2,
      SRC_DEDICATED     = 4'h3,
      SRC_HIGH_VOLTAGE  = 4'h4,
      SRC_UNKNOWN       = 4'h5,
      SRC_NONSTANDARD   = 4'h6,
      SRC_UNQUALIFIED   = 4'h8,
      SRC_DIRECT_BUS    = 4'hb
   } source_type_t;

   typedef enum logic [1:0] {
      OPT_DISABLED = 2'h0,
      OPT_RUNNING  = 2'h1,
      OPT_FOUND    = 2'h2,
      OPT_RSVD     = 2'h3
   } optimizer_t;

   // levels from the analog monitors and comparators
   typedef struct packed {
      logic          input_current_regulating;
      logic          input_voltage_regulating;
      logic          watchdog_expired_status;
      logic          weak_source_status;
      logic          input_good_status;
      logic          second_source_present;
      logic          first_source_present;
      logic          bus_input_present;
      charge_phase_t charge_phase;
      source_type_t  input_source_type;
      logic          adapter_detect_done;
      optimizer_t    current_optimizer_state;
      logic          die_thermal_regulation;
      logic          data_line_detect_busy;
      logic          battery_present;
      logic          second_blocking_pair_fitted;
      logic          first_blocking_pair_fitted;
      logic          conversion_done;
      logic          system_min_regulation;
      logic          fast_timer_expired;
      logic          trickle_timer_expired;
      logic          precharge_timer_expired;
      logic          thermistor_cold;
      logic          thermistor_cool;
      logic          thermistor_warm;
      logic          thermistor_hot;
      logic          discharge_current_regulating;
      logic          bus_overvoltage;
      logic          battery_overvoltage;
      logic          bus_overcurrent;
      logic          battery_overcurrent;
      logic          converter_overcurrent;
      logic          second_source_overvoltage;
      logic          first_source_overvoltage;
      logic          system_rail_short;
      logic          system_rail_overvoltage;
      logic          thermal_shutdown_active;
   } monitor_t;

   typedef struct packed {
      monitor_t    sync1;
      monitor_t    sync2;
      monitor_t    prev;
      logic [7:0]  flags;
      logic [7:0]  rd_data;
      logic        rd_valid;
      logic        int_pulse;
   } bank_state_t;

endpackage

// [sim/charger_status_flag_bank_assertions.sv]
`timescale 1ns/1ps
module charger_status_flag_bank_assertions (
   // clock and reset
   input wire logic                         ref_clk_i,
   input wire logic                         rstn_i,
   // watched inputs
   input wire charger_status_pkg::monitor_t monitor_i,
   input wire logic [7:0]                   event_mask_i,
   input wire logic                         rd_en_i,
   input wire logic [7:0]                   rd_addr_i,
   // watched outputs
   input wire logic [7:0]                   rd_data_o,
   input wire logic                         rd_valid_o,
   input wire logic                         int_pulse_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rstn_i);
   a_reset_quiet: assert property (
      $rose(rstn_i) |-> !rd_valid_o && !int_pulse_o && rd_data_o == 8'h00)
      else $error("outputs not quiet after reset");
   a_read_answer: assert property (rd_en_i |=> rd_valid_o)
      else $error("read not answered next cycle");
   a_no_spurious: assert property (!rd_en_i |=> !rd_valid_o)
      else $error("valid without read");
   a_unmapped_zero: assert property (
      rd_en_i && (rd_addr_i < 8'h1b || rd_addr_i > 8'h22) |=> rd_data_o == 8'h00)
      else $error("unmapped read not zero");
   a_therm_reserved: assert property (
      rd_en_i && rd_addr_i == 8'h1f |=> rd_data_o[7:4] == 4'h0)
      else $error("thermistor reserved bits set");
   a_sec_reserved: assert property (
      rd_en_i && rd_addr_i == 8'h21 |=> rd_data_o[5:3] == 3'h0 && rd_data_o[1:0] == 2'h0)
      else $error("secondary reserved bits set");
   a_opt_reserved: assert property (
      rd_en_i && rd_addr_i == 8'h1d |=> rd_data_o[5:3] == 3'h0)
      else $error("optimizer reserved bits set");
   a_timer_reserved: assert property (
      rd_en_i && rd_addr_i == 8'h1e |=> !rd_data_o[0])
      else $error("timer reserved bit set");
   a_mask_silence: assert property (event_mask_i == 8'hff |=> !int_pulse_o)
      else $error("pulse while all masked");
endmodule

// [sim/host_reader.sv]
`timescale 1ns/1ps
module host_reader (
   // clock
   input  wire logic       ref_clk_i,
   // read port
   output logic            rd_en_o,
   output logic [7:0]      rd_addr_o,
   input  wire logic [7:0] rd_data_i,
   input  wire logic       rd_valid_i
);
   initial begin
      rd_en_o   = 1'b0;
      rd_addr_o = 8'h00;
   end
   // idle address is scrambled so no stale offset is mistaken for a request
   task automatic read(input logic [7:0] a, output logic [7:0] d, output logic ok);
      @(posedge ref_clk_i);
      rd_en_o   <= 1'b1;
      rd_addr_o <= a;
      @(posedge ref_clk_i);
      rd_en_o   <= 1'b0;
      rd_addr_o <= ~a;
      #1;
      d  = rd_data_i;
      ok = rd_valid_i;
   endtask
endmodule

// [sim/tb_charger_status_flag_bank.sv]
`timescale 1ns/1ps
`define CHK(n, e, s) begin comparisons++; if ((e) !== (s)) begin num_errors++; \
   $display("[ERR] %s exp %h got %h", n, e, s); end end
module tb_charger_status_flag_bank;
   logic ref_clk_i = 1'b0;
   logic rstn_i = 1'b0;
   charger_status_pkg::monitor_t mon = '0;
   logic [7:0] mask = 8'h00, rd_addr, rd_data, d, fl, ev;
   logic rd_en, rd_valid, int_pulse, ok;
   int num_errors = 0, comparisons = 0, pulses = 0, cycles = 0;
   always #2.5 ref_clk_i = ~ref_clk_i;
   always @(posedge ref_clk_i) begin
      cycles++;
      if (int_pulse === 1'b1) pulses++;
      if (cycles == 20000) begin
         num_errors++;
         give_verdict();
      end
   end
   charger_status_flag_bank charger_status_flag_bank_i (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
      .monitor_i(mon), .event_mask_i(mask), .rd_en_i(rd_en), .rd_addr_i(rd_addr),
      .rd_data_o(rd_data), .rd_valid_o(rd_valid), .int_pulse_o(int_pulse));
   host_reader host_reader_i (.ref_clk_i(ref_clk_i), .rd_en_o(rd_en), .rd_addr_o(rd_addr),
      .rd_data_i(rd_data), .rd_valid_i(rd_valid));
   function automatic logic [7:0] exp_byte(charger_status_pkg::monitor_t m, logic [7:0] a);
      case (a)
         8'h1b: return {m.input_current_regulating, m.input_voltage_regulating,
            m.watchdog_expired_status, m.weak_source_status, m.input_good_status,
            m.second_source_present, m.first_source_present, m.bus_input_present};
         8'h1c: return {m.charge_phase, m.input_source_type, m.adapter_detect_done};
         8'h1d: return {m.current_optimizer_state, 3'h0, m.die_thermal_regulation,
            m.data_line_detect_busy, m.battery_present};
         8'h1e: return {m.second_blocking_pair_fitted, m.first_blocking_pair_fitted,
            m.conversion_done, m.system_min_regulation, m.fast_timer_expired,
            m.trickle_timer_expired, m.precharge_timer_expired, 1'b0};
         8'h1f: return {4'h0, m.thermistor_cold, m.thermistor_cool, m.thermistor_warm,
            m.thermistor_hot};
         8'h20: return {m.discharge_current_regulating, m.bus_overvoltage,
            m.battery_overvoltage, m.bus_overcurrent, m.battery_overcurrent,
            m.converter_overcurrent, m.second_source_overvoltage, m.first_source_overvoltage};
         8'h21: return {m.system_rail_short, m.system_rail_overvoltage, 3'h0,
            m.thermal_shutdown_active, 2'h0};
         default: return 8'h00;
      endcase
   endfunction
   task automatic give_verdict();
      $display("checks %0d errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // sweeps one offset below and one above the map, flags compared against the model
   task automatic read_all();
      for (int a = 8'h1a; a <= 8'h23; a++) begin
         host_reader_i.read(a[7:0], d, ok);
         `CHK("valid", 1'b1, ok)
         if (a == 8'h22) begin
            `CHK("flags", fl, d)
            fl = 8'h00;
         end else begin
            `CHK("status", exp_byte(mon, a[7:0]), d)
         end
      end
   endtask
   initial begin
      charger_status_pkg::monitor_t nxt;
      void'($urandom(32'hfca6));
      fl = 8'h00;
      repeat (3) @(posedge ref_clk_i);
      rstn_i <= 1'b1;
      read_all();
      for (int i = 0; i < 40; i++) begin
         nxt = $bits(charger_status_pkg::monitor_t)'({$urandom, $urandom});
         ev = (exp_byte(nxt, 8'h1b) & ~exp_byte(mon, 8'h1b) & 8'hf0) |
              ((exp_byte(nxt, 8'h1b) ^ exp_byte(mon, 8'h1b)) & 8'h0f);
         fl = fl | ev;
         @(posedge ref_clk_i);
         mon  <= nxt;
         mask <= (i % 3 == 0) ? 8'hff : 8'($urandom);
         pulses = 0;
         repeat (5) @(posedge ref_clk_i);
         `CHK("pulses", ((ev & ~mask) != 8'h00) ? 1 : 0, pulses)
         read_all();
      end
      host_reader_i.read(8'h22, d, ok);
      `CHK("flags cleared", 8'h00, d)
      give_verdict();
   end
endmodule
bind charger_status_flag_bank charger_status_flag_bank_assertions charger_status_flag_bank_assertions_i (
   .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .monitor_i(monitor_i), .event_mask_i(event_mask_i),
   .rd_en_i(rd_en_i), .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
   .int_pulse_o(int_pulse_o));
